// ### stom_regs.svh
// Register indices, field positions, reset values and timing constants of the monitor.
`ifndef STOM_REGS_SVH
`define STOM_REGS_SVH

`define STOM_ADDR_W 4
`define STOM_IDX_IN_WORD 4'h0
`define STOM_IDX_IN_FIRST 4'h1
`define STOM_IDX_IN_SECOND 4'h2
`define STOM_IDX_FLT_WORD 4'h3
`define STOM_IDX_FLT_FIRST 4'h4
`define STOM_IDX_FLT_SECOND 4'h5
`define STOM_IDX_STATUS 4'h6
`define STOM_IDX_DISP_CODE 4'h7
`define STOM_IDX_CTRL 4'h8
`define STOM_IDX_OTHER_ERR 4'h9

`define STOM_BIT_FIRST 0
`define STOM_BIT_SECOND 1
`define STOM_BIT_CLEAR 0
`define STOM_BIT_DP 15

`define STOM_CODE_W 16
`define STOM_CODE_OFF 16'h2731
`define STOM_CODE_FLT_FIRST 16'h2732
`define STOM_CODE_FLT_SECOND 16'h2733
`define STOM_OTHER_ERR_RST 16'h0000

`define STOM_SKEW_US 1000
`define STOM_CLK_PERIOD_NS 4
`define STOM_NS_PER_US 1000

`endif

// ### stom_pkg.sv
// Types shared by the safe-off monitor modules.
package stom_pkg;
    typedef enum logic [0:0] {
        ST_SAFE_OFF = 1'b0,
        ST_STANDBY = 1'b1
    } stom_state_e;
    typedef logic [15:0] stom_code_t;
endpackage : stom_pkg

// ### stom_skew_chan.sv
// One channel of the discrepancy check between the two safe-off inputs.
`timescale 1ns/1ns
`default_nettype none
`include "stom_regs.svh"
module stom_skew_chan #(
    parameter int SKEW_CYC = (`STOM_SKEW_US * `STOM_NS_PER_US) / `STOM_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs of this channel and of its partner
    input wire logic own,
    input wire logic partner,
    // Clear request already qualified by both inputs powered
    input wire logic clear_ok,
    // Latched hardware fault of this channel
    output logic fault
);
    localparam int CNT_W = $clog2(SKEW_CYC + 1);
    localparam logic [CNT_W-1:0] SKEW_MAX = CNT_W'(SKEW_CYC);

    logic own_q;
    logic partner_q;
    logic moved;
    logic [CNT_W-1:0] cnt;
    logic next_own_q;
    logic next_partner_q;
    logic next_moved;
    logic [CNT_W-1:0] next_cnt;
    logic next_fault;
    logic mismatch;
    logic own_edge;
    logic partner_edge;
    logic set_fault;

    always_comb begin
        mismatch = own ^ partner;
        own_edge = own ^ own_q;
        partner_edge = partner ^ partner_q;
        next_own_q = own;
        next_partner_q = partner;
        // A channel that moved alone is not the lagging one; a joint move blames both.
        next_moved = mismatch & ~partner_edge & (moved | own_edge);
        if (!mismatch) begin
            next_cnt = '0;
        end else if (cnt == SKEW_MAX) begin
            next_cnt = cnt;
        end else begin
            next_cnt = cnt + CNT_W'(1);
        end
        set_fault = mismatch && (cnt == SKEW_MAX) && !next_moved;
        next_fault = set_fault | (fault & ~clear_ok);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            own_q <= 1'b0;
            partner_q <= 1'b0;
            moved <= 1'b0;
            cnt <= '0;
            fault <= 1'b0;
        end else begin
            own_q <= next_own_q;
            partner_q <= next_partner_q;
            moved <= next_moved;
            cnt <= next_cnt;
            fault <= next_fault;
        end
    end
endmodule : stom_skew_chan
`default_nettype wire

// ### stom_display.sv
// Front-panel status code and right-hand decimal point driver.
`timescale 1ns/1ns
`default_nettype none
`include "stom_regs.svh"
module stom_display
    import stom_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Error sources
    input wire logic sto_err,
    input wire logic flt_first,
    input wire logic flt_second,
    input wire stom_code_t other_code,
    // Display outputs
    output stom_code_t disp_code,
    output logic disp_dp
);
    stom_code_t next_code;
    logic next_dp;

    always_comb begin
        // A safe-off error outranks any other error the firmware wants to show.
        if (!sto_err) begin
            next_code = other_code;
        end else if (flt_first) begin
            next_code = `STOM_CODE_FLT_FIRST;
        end else if (flt_second) begin
            next_code = `STOM_CODE_FLT_SECOND;
        end else begin
            next_code = `STOM_CODE_OFF;
        end
        next_dp = sto_err;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            disp_code <= `STOM_OTHER_ERR_RST;
            disp_dp <= 1'b0;
        end else begin
            disp_code <= next_code;
            disp_dp <= next_dp;
        end
    end
endmodule : stom_display
`default_nettype wire

// ### stom_monitor.sv
// Safe-off monitor top: power-stage gating, discrepancy faults, status registers.
`timescale 1ns/1ns
`default_nettype none
`include "stom_regs.svh"
module stom_monitor
    import stom_pkg::*;
#(
    parameter int SKEW_CYC = (`STOM_SKEW_US * `STOM_NS_PER_US) / `STOM_CLK_PERIOD_NS,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Safety inputs, high while powered
    input wire logic first_safe_off_input,
    input wire logic second_safe_off_input,
    // Register port
    input wire logic [`STOM_ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // Power stage and status
    output logic power_stage_en,
    output logic status_out,
    // Front-panel display
    output stom_code_t disp_code,
    output logic disp_dp
);
    localparam int CNT_W = $clog2(SKEW_CYC + 1);

    stom_state_e state;
    stom_state_e next_state;
    logic next_en;
    logic [DATA_W-1:0] next_rdata;
    stom_code_t other_err;
    stom_code_t next_other_err;
    logic both_on;
    logic clr_pulse;
    logic clear_ok;
    logic flt_first;
    logic flt_second;
    logic [1:0] in_word;
    logic [1:0] flt_word;

    assign in_word = {second_safe_off_input, first_safe_off_input};
    assign flt_word = {flt_second, flt_first};
    assign both_on = first_safe_off_input & second_safe_off_input;
    assign clr_pulse = wr && (addr == `STOM_IDX_CTRL) && wdata[`STOM_BIT_CLEAR];
    assign clear_ok = clr_pulse & both_on;

    stom_skew_chan #(
        .SKEW_CYC(SKEW_CYC)
    ) u_chan_first (
        .clk(clk),
        .rst(rst),
        .own(first_safe_off_input),
        .partner(second_safe_off_input),
        .clear_ok(clear_ok),
        .fault(flt_first)
    );

    stom_skew_chan #(
        .SKEW_CYC(SKEW_CYC)
    ) u_chan_second (
        .clk(clk),
        .rst(rst),
        .own(second_safe_off_input),
        .partner(first_safe_off_input),
        .clear_ok(clear_ok),
        .fault(flt_second)
    );

    // The stage starts off after reset, so power-up itself needs a clear.
    always_comb begin
        next_state = state;
        case (state)
            ST_STANDBY: begin
                if (!both_on) begin
                    next_state = ST_SAFE_OFF;
                end
            end
            ST_SAFE_OFF: begin
                if (clear_ok) begin
                    next_state = ST_STANDBY;
                end
            end
            default: begin
                next_state = ST_SAFE_OFF;
            end
        endcase
        next_en = (next_state == ST_STANDBY);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_SAFE_OFF;
            power_stage_en <= 1'b0;
            status_out <= 1'b0;
        end else begin
            state <= next_state;
            power_stage_en <= next_en;
            status_out <= next_en;
        end
    end

    // Register file: one writable code, one clear strobe, the rest read-only state.
    always_comb begin
        next_other_err = other_err;
        if (wr && (addr == `STOM_IDX_OTHER_ERR)) begin
            next_other_err = wdata[`STOM_CODE_W-1:0];
        end
        next_rdata = '0;
        if (rd) begin
            case (addr)
                `STOM_IDX_IN_WORD: next_rdata[1:0] = in_word;
                `STOM_IDX_IN_FIRST: next_rdata[0] = first_safe_off_input;
                `STOM_IDX_IN_SECOND: next_rdata[0] = second_safe_off_input;
                `STOM_IDX_FLT_WORD: next_rdata[1:0] = flt_word;
                `STOM_IDX_FLT_FIRST: next_rdata[0] = flt_first;
                `STOM_IDX_FLT_SECOND: next_rdata[0] = flt_second;
                `STOM_IDX_STATUS: next_rdata[0] = status_out;
                `STOM_IDX_DISP_CODE: next_rdata[`STOM_CODE_W-1:0] = disp_code;
                `STOM_IDX_OTHER_ERR: next_rdata[`STOM_CODE_W-1:0] = other_err;
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            other_err <= `STOM_OTHER_ERR_RST;
            rdata <= '0;
        end else begin
            other_err <= next_other_err;
            rdata <= next_rdata;
        end
    end

    stom_display u_display (
        .clk(clk),
        .rst(rst),
        .sto_err(state == ST_SAFE_OFF),
        .flt_first(flt_first),
        .flt_second(flt_second),
        .other_code(other_err),
        .disp_code(disp_code),
        .disp_dp(disp_dp)
    );

    // Helper for the skew check: how long the inputs have disagreed, saturating.
    logic [CNT_W-1:0] mlen;
    logic [CNT_W-1:0] next_mlen;
    logic mism;
    assign mism = first_safe_off_input ^ second_safe_off_input;
    always_comb begin
        if (!mism) begin
            next_mlen = '0;
        end else if (mlen == CNT_W'(SKEW_CYC)) begin
            next_mlen = mlen;
        end else begin
            next_mlen = mlen + CNT_W'(1);
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            mlen <= '0;
        end else begin
            mlen <= next_mlen;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_rd_in_word;
        rd && (addr == `STOM_IDX_IN_WORD);
    endsequence
    sequence s_rd_flt_first;
        rd && (addr == `STOM_IDX_FLT_FIRST);
    endsequence
    sequence s_rd_status;
        rd && (addr == `STOM_IDX_STATUS);
    endsequence
    sequence s_rd_in_first;
        rd && (addr == `STOM_IDX_IN_FIRST);
    endsequence
    sequence s_rd_in_second;
        rd && (addr == `STOM_IDX_IN_SECOND);
    endsequence
    sequence s_rd_flt_word;
        rd && (addr == `STOM_IDX_FLT_WORD);
    endsequence
    sequence s_rd_flt_second;
        rd && (addr == `STOM_IDX_FLT_SECOND);
    endsequence
    sequence s_rd_disp_code;
        rd && (addr == `STOM_IDX_DISP_CODE);
    endsequence
    // The display trails the stage by one cycle, so the one cycle right after reset is skipped.
    sequence s_off_settled;
        !$past(rst) && !power_stage_en;
    endsequence

    chk_run_needs_inputs: assert property (
        power_stage_en |-> $past(both_on))
        else $error("Power stage enabled without both inputs powered.");
    chk_loss_disables: assert property (
        !both_on |=> !power_stage_en && !status_out)
        else $error("Input loss did not disable stage and status.");
    chk_no_restart: assert property (
        !power_stage_en && !clear_ok |=> !power_stage_en)
        else $error("Stage restarted without a valid clear.");
    chk_clear_restarts: assert property (
        !power_stage_en && clear_ok |=> power_stage_en && status_out)
        else $error("Valid clear did not restart the stage.");
    chk_in_word_read: assert property (
        s_rd_in_word |=> rdata[1:0] == {$past(second_safe_off_input),
                                        $past(first_safe_off_input)})
        else $error("Input word read back wrong.");
    chk_flt_bit_read: assert property (
        s_rd_flt_first |=> rdata[0] == $past(flt_first))
        else $error("First channel fault bit read back wrong.");
    chk_status_read: assert property (
        s_rd_status |=> rdata[0] == $past(status_out))
        else $error("Status bit read back wrong.");
    chk_dp_only_sto: assert property (
        s_off_settled ##1 !power_stage_en |-> disp_dp && (disp_code == `STOM_CODE_OFF
            || disp_code == `STOM_CODE_FLT_FIRST || disp_code == `STOM_CODE_FLT_SECOND))
        else $error("Safe-off error not shown on the display.");
    chk_dp_off_running: assert property (
        power_stage_en ##1 power_stage_en |-> !disp_dp)
        else $error("Decimal point lit without a safe-off error.");
    chk_skew_fault: assert property (
        mism && (mlen == CNT_W'(SKEW_CYC)) |=> (flt_first || flt_second) && !power_stage_en)
        else $error("Input skew beyond the limit did not latch a fault.");
    chk_fault_hold: assert property (
        (flt_first || flt_second) && !clear_ok |=> (flt_first || flt_second))
        else $error("Discrepancy fault dropped without a valid clear.");

    // Read-back, display and fault-path checks on what the block drives.
    chk_in_first_read: assert property (
        s_rd_in_first |=> rdata[0] == $past(first_safe_off_input))
        else $error("First input bit read back wrong.");
    chk_in_second_read: assert property (
        s_rd_in_second |=> rdata[0] == $past(second_safe_off_input))
        else $error("Second input bit read back wrong.");
    chk_flt_word_read: assert property (
        s_rd_flt_word |=> rdata[1:0] == {$past(flt_second), $past(flt_first)})
        else $error("Fault word read back wrong.");
    chk_flt_second_read: assert property (
        s_rd_flt_second |=> rdata[0] == $past(flt_second))
        else $error("Second channel fault bit read back wrong.");
    chk_code_read: assert property (
        s_rd_disp_code |=> rdata == $past(disp_code))
        else $error("Display code read back wrong.");
    chk_code_first: assert property (
        !power_stage_en && flt_first |=> disp_code == `STOM_CODE_FLT_FIRST)
        else $error("First channel fault code not shown.");
    chk_code_second: assert property (
        !power_stage_en && !flt_first && flt_second |=> disp_code == `STOM_CODE_FLT_SECOND)
        else $error("Second channel fault code not shown.");
    chk_code_plain: assert property (
        !$past(rst) && !power_stage_en && !flt_first && !flt_second
            |=> disp_code == `STOM_CODE_OFF)
        else $error("Plain safe-off code not shown.");
    chk_code_running: assert property (
        power_stage_en |=> disp_code == $past(other_err))
        else $error("Running display does not show the firmware code.");
    chk_dp_lit: assert property (
        s_off_settled |=> disp_dp)
        else $error("Decimal point dark during a safe-off error.");
    chk_fault_stops_stage: assert property (
        flt_first || flt_second |-> !power_stage_en)
        else $error("Power stage enabled while a fault is latched.");
    chk_fault_status: assert property (
        flt_first || flt_second |-> !status_out)
        else $error("Status output high while a fault is latched.");
    chk_skew_quiet: assert property (
        !(flt_first || flt_second) && !(mism && (mlen == CNT_W'(SKEW_CYC)))
            |=> !(flt_first || flt_second))
        else $error("Fault latched although the skew stayed within the limit.");
    chk_clear_drops: assert property (
        clear_ok |=> !flt_first && !flt_second)
        else $error("Valid clear left a fault latched.");
    chk_clear_refused: assert property (
        clr_pulse && !both_on && !power_stage_en |=> !power_stage_en)
        else $error("Clear with an unpowered input restarted the stage.");
endmodule : stom_monitor
`default_nettype wire

// ### stom_contacts.sv
// Behavioural model of the two external safety contacts.
`timescale 1ns/1ns
`default_nettype none
module stom_contacts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command from the bench
    input wire logic go,
    input wire logic lvl,
    input wire logic lead_second,
    input wire logic [7:0] lag,
    // Contact outputs, high while powered
    output logic first_safe_off_input,
    output logic second_safe_off_input
);
    logic [7:0] cnt;
    logic pend;
    // The slow contact trails by lag cycles, so a lag past the limit acts as a wiring fault.
    always @(posedge clk) begin
        if (rst) begin
            first_safe_off_input <= 1'b0;
            second_safe_off_input <= 1'b0;
            pend <= 1'b0;
            cnt <= 8'h00;
        end else if (go) begin
            if (lead_second || lag == 8'h00) second_safe_off_input <= lvl;
            if (!lead_second || lag == 8'h00) first_safe_off_input <= lvl;
            cnt <= lag;
            pend <= (lag != 8'h00);
        end else if (pend) begin
            cnt <= cnt - 8'h01;
            if (cnt <= 8'h01) begin
                pend <= 1'b0;
                if (lead_second) first_safe_off_input <= lvl;
                else second_safe_off_input <= lvl;
            end
        end
    end
endmodule : stom_contacts
`default_nettype wire

// ### tb_top.sv
// Self-checking bench of the safe-off monitor.
`timescale 1ns/1ns
`default_nettype none
`include "stom_regs.svh"
module tb_top;
    import stom_pkg::*;
    localparam int SKEW = 8;
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, lvl = 1'b0, lsec = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] lag = 8'h00;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, other;
    logic in1, in2, en, stat, dp, f1, f2;
    stom_code_t code;
    int bad_count = 0, n_checks = 0, cyc = 0, seed = 83253, i;
    always #2 clk = ~clk;
    stom_contacts stom_contacts_inst (.clk(clk), .rst(rst), .go(go), .lvl(lvl),
        .lead_second(lsec), .lag(lag), .first_safe_off_input(in1),
        .second_safe_off_input(in2));
    stom_monitor #(.SKEW_CYC(SKEW)) stom_monitor_inst (.clk(clk), .rst(rst),
        .first_safe_off_input(in1), .second_safe_off_input(in2), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .power_stage_en(en),
        .status_out(stat), .disp_code(code), .disp_dp(dp));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16
    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1
    function automatic logic [15:0] exp_code(input logic a, input logic b, input logic off);
        if (a) return `STOM_CODE_FLT_FIRST;
        if (b) return `STOM_CODE_FLT_SECOND;
        return off ? `STOM_CODE_OFF : other;
    endfunction : exp_code
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk16("rdata", e, rdata);
    endtask : rd_reg
    task automatic move(input logic l, input logic s, input logic [7:0] g);
        @(posedge clk);
        go <= 1'b1;
        lvl <= l;
        lsec <= s;
        lag <= g;
        @(posedge clk);
        go <= 1'b0;
        repeat (int'(g) + 3) @(posedge clk);
    endtask : move
    // Outputs are sampled just after the edge, once the registered values have landed.
    task automatic check_out(input logic e_en, input logic e_dp, input logic [15:0] e_code);
        repeat (2) @(posedge clk);
        #1 chk1("power_stage_en", e_en, en);
        chk1("status_out", e_en, stat);
        chk1("disp_dp", e_dp, dp);
        chk16("disp_code", e_code, code);
    endtask : check_out
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        check_out(1'b0, 1'b1, `STOM_CODE_OFF);
        rd_reg(4'h6, 16'h0000);
        other = 16'($random(seed));
        wr_reg(4'h9, other);
        rd_reg(4'h9, other);
        move(1'b1, 1'b0, 8'h00);
        wr_reg(4'h8, 16'h0001);
        check_out(1'b1, 1'b0, other);
        rd_reg(4'h0, 16'h0003);
        rd_reg(4'h1, 16'h0001);
        rd_reg(4'h2, 16'h0001);
        rd_reg(4'h6, 16'h0001);
        rd_reg(4'h7, other);
        wr_reg(4'h3, 16'hFFFF);
        rd_reg(4'h3, 16'h0000);
        rd_reg(4'hC, 16'h0000);
        // Skews up to the limit, the limit itself first, must not latch a fault.
        for (i = 0; i < 6; i++) begin
            lsec = 1'($random(seed));
            lag = (i == 0) ? 8'(SKEW) : 8'($unsigned($random(seed)) % (SKEW + 1));
            move(1'b0, lsec, lag);
            check_out(1'b0, 1'b1, `STOM_CODE_OFF);
            rd_reg(4'h3, 16'h0000);
            wr_reg(4'h8, 16'h0001);
            check_out(1'b0, 1'b1, `STOM_CODE_OFF);
            move(1'b1, ~lsec, lag);
            rd_reg(4'h0, 16'h0003);
            wr_reg(4'h8, 16'h0001);
            check_out(1'b1, 1'b0, other);
        end
        // One cycle past the limit blames the lagging channel and stays latched.
        for (i = 0; i < 2; i++) begin
            f1 = i[0];
            f2 = ~i[0];
            move(1'b0, i[0], 8'(SKEW + 1));
            rd_reg(4'h3, {14'h0000, f2, f1});
            rd_reg(4'h4, {15'h0000, f1});
            rd_reg(4'h5, {15'h0000, f2});
            check_out(1'b0, 1'b1, exp_code(f1, f2, 1'b1));
            rd_reg(4'h7, exp_code(f1, f2, 1'b1));
            move(1'b1, 1'b0, 8'h00);
            repeat (20) @(posedge clk);
            rd_reg(4'h3, {14'h0000, f2, f1});
            check_out(1'b0, 1'b1, exp_code(f1, f2, 1'b1));
            wr_reg(4'h8, 16'h0001);
            check_out(1'b1, 1'b0, other);
            rd_reg(4'h3, 16'h0000);
        end
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
